// >>> carf_checker.sv
// Purpose: Port-level assertions for the architectural register file.
// Assumes: Sampled on sys_clk and disabled while rst is high.
// Notes: Bound to the register file from the testbench top file.
`timescale 1ns/10ps
module carf_checker
   import carf_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Inputs watched.
   input wire logic protection_enable,
   input wire logic [1:0] current_privilege,
   input wire carf_gpr_wr_t gprWr,
   input wire logic [2:0] gprRdIdx,
   input wire logic stringStep,
   input wire logic ipLoad,
   input wire logic [31:0] ipNext,
   input wire carf_flagsrc_t flagSrc,
   input wire logic maskable_irq_input,
   input wire logic instrDone,
   input wire logic instrFault,
   input wire logic ioInstr,
   input wire logic privOpcode,
   // Outputs watched.
   input wire logic [31:0] addrRegData,
   input wire logic [31:0] instruction_pointer,
   input wire logic [15:0] ipShort,
   input wire logic [31:0] processor_flags,
   input wire logic [31:0] flag_push,
   input wire logic irqTaken,
   input wire logic iretInterTask,
   input wire logic excRaise,
   input wire logic [7:0] excVector
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   ip_short_a: assert property (ipShort == instruction_pointer[15:0])
      else $error("pointer low half mismatch");
   ip_load_a: assert property (ipLoad |=>
      instruction_pointer == $past(ipNext)) else $error("pointer load lost");
   word_write_a: assert property (gprWr.en && gprWr.size == SZ_WORD &&
      !stringStep && gprWr.idx == gprRdIdx ##1 $stable(gprRdIdx) |->
      addrRegData == {$past(addrRegData[31:16]), $past(gprWr.data[15:0])})
      else $error("word write touched upper half");
   push_mask_a: assert property (flag_push ==
      {processor_flags[31:18], 1'b0, processor_flags[16:0]})
      else $error("pushed image wrong");
   pop_legacy_a: assert property (flagSrc == FS_POP |=>
      $stable(processor_flags[VLEG_BIT]))
      else $error("pop changed legacy bit");
   pop_io_privilege_field_a: assert property (flagSrc == FS_POP &&
      protection_enable && current_privilege != PRIV0 |=>
      $stable(processor_flags[13:12]))
      else $error("pop changed io privilege");
   irq_gate_a: assert property (irqTaken ==
      (maskable_irq_input && processor_flags[INTEN_BIT]))
      else $error("interrupt gating wrong");
   return_kind_a: assert property (iretInterTask ==
      (protection_enable && processor_flags[NEST_BIT]))
      else $error("return kind wrong");
   fixed_bits_a: assert property (
      (processor_flags & ~FLAG_DEFINED_MASK) == FLAG_FIXED_VALUE)
      else $error("undefined flag bits moved");
   step_trap_a: assert property (instrDone && !instrFault &&
      !ioInstr && !privOpcode && processor_flags[TRAP_BIT] &&
      !processor_flags[RESUME_BIT] |=> excRaise && excVector == EXC_DEBUG)
      else $error("step trap missing");
   priv_fault_a: assert property (privOpcode && protection_enable &&
      processor_flags[VLEG_BIT] |=> excRaise && excVector == EXC_GP)
      else $error("privileged opcode not faulted");
endmodule : carf_checker

// >>> carf_pkg.sv
// Purpose: Constants and carrier types for the architectural register file.
// Assumes: One core clock; the execution unit sequences every update.
// Notes: Reset values are neutral choices; flag bit positions are fixed.
package carf_pkg;
   localparam int NUM_GPR = 8;
   localparam int NUM_SEG = 6;
   // Flag bit positions.
   localparam int CARRY_BIT = 0;
   localparam int PARITY_BIT = 2;
   localparam int AUX_BIT = 4;
   localparam int ZERO_BIT = 6;
   localparam int SIGN_BIT = 7;
   localparam int TRAP_BIT = 8;
   localparam int INTEN_BIT = 9;
   localparam int DIR_BIT = 10;
   localparam int OVF_BIT = 11;
   localparam int IO_PRIVILEGE_FIELD_LO = 12;
   localparam int IO_PRIVILEGE_FIELD_HI = 13;
   localparam int NEST_BIT = 14;
   localparam int RESUME_BIT = 16;
   localparam int VLEG_BIT = 17;
   // Undefined positions: bit 1 reads one, the rest read zero.
   localparam logic [31:0] FLAG_DEFINED_MASK = 32'h00037FD5;
   localparam logic [31:0] FLAG_FIXED_VALUE = 32'h00000002;
   localparam logic [31:0] FLAG_STATUS_MASK = 32'h000008D5;
   localparam logic [31:0] FLAG_RESET = 32'h00000002;
   localparam logic [31:0] IP_RESET = 32'h00000000;
   localparam logic [31:0] GPR_RESET = 32'h00000000;
   localparam logic [15:0] SEL_RESET = 16'h0000;
   localparam logic [31:0] REAL_LIMIT = 32'h0000FFFF;
   localparam logic [11:0] REAL_ATTR = 12'h093;
   localparam int SEL_SHIFT = 4;
   localparam logic [7:0] EXC_GP = 8'h0D;
   localparam logic [7:0] EXC_DEBUG = 8'h01;
   localparam logic [1:0] PRIV0 = 2'h0;

   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} carf_size_t;
   typedef enum logic [2:0] {
      FS_NONE, FS_POP, FS_INTERRUPT_RETURN, FS_TASK, FS_ALU
   } carf_flagsrc_t;

   typedef struct packed {
      logic en;
      logic [2:0] idx;
      carf_size_t size;
      logic highByte;
      logic [31:0] data;
   } carf_gpr_wr_t;

   typedef struct packed {
      logic [31:0] base;
      logic [31:0] limit;
      logic [11:0] attr;
   } carf_desc_t;

   typedef struct packed {
      logic en;
      logic [2:0] seg;
      logic [15:0] selector;
      carf_desc_t desc;
   } carf_seg_wr_t;

   typedef struct packed {
      logic valid;
      logic [2:0] seg;
      logic [31:0] offset;
      logic [3:0] accessType;
   } carf_memref_t;

   typedef struct packed {
      logic [31:0] linear;
      logic limitFault;
      logic attrFault;
   } carf_memchk_t;

   typedef struct packed {
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] result;
      logic subtract;
      carf_size_t size;
   } carf_alu_t;
endpackage : carf_pkg

// >>> carf_regfile.sv
// Purpose: General registers, instruction pointer, flags and segments.
// Assumes: The decoder issues one update of each kind per cycle.
// Notes: Popped and returned flag images are merged under the privilege masks below.
`timescale 1ns/10ps
module carf_regfile
   import carf_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Mode and privilege.
   input wire logic protection_enable,
   input wire logic [1:0] current_privilege,
   // General register access.
   input wire carf_gpr_wr_t gprWr,
   input wire logic [2:0] gprRdIdx,
   input wire carf_size_t gprRdSize,
   input wire logic gprRdHigh,
   output logic [31:0] gprRdData,
   output logic [31:0] addrRegData,
   // Instruction pointer.
   input wire logic ipLoad,
   input wire logic [31:0] ipNext,
   output logic [31:0] instruction_pointer,
   output logic [15:0] ipShort,
   // Flags.
   input wire carf_flagsrc_t flagSrc,
   input wire logic [31:0] flagImage,
   input wire carf_alu_t alu,
   input wire logic taskNested,
   input wire logic instrDone,
   input wire logic instrFault,
   output logic [31:0] processor_flags,
   output logic [31:0] flag_push,
   // Instruction checks.
   input wire logic ioInstr,
   input wire logic privOpcode,
   input wire logic debugHit,
   input wire logic stringStep,
   input wire carf_size_t stringSize,
   input wire logic maskable_irq_input,
   output logic ioNeedsBitmap,
   output logic excRaise,
   output logic [7:0] excVector,
   output logic irqTaken,
   output logic iretInterTask,
   // Segments.
   input wire carf_seg_wr_t segWr,
   input wire carf_memref_t memRef,
   output carf_memchk_t memChk,
   output logic [15:0] selOut [NUM_SEG]
);
   typedef struct packed {
      logic [NUM_GPR-1:0][31:0] gpr;
      logic [31:0] ip;
      logic [31:0] flags;
      logic [31:0] rdData;
      logic exc;
      logic [7:0] vec;
   } carf_state_t;

   carf_state_t state;
   carf_state_t next_state;
   logic legacyMode;
   logic ioOk;

   assign legacyMode = protection_enable && state.flags[VLEG_BIT];
   assign ioOk = !protection_enable ||
      (!legacyMode && current_privilege <= state.flags[IO_PRIVILEGE_FIELD_HI:IO_PRIVILEGE_FIELD_LO]);

   function automatic logic [31:0] alu_flags(input carf_alu_t x,
                                             input logic [31:0] f);
      logic [32:0] wide;
      logic [31:0] r;
      logic [31:0] cin;
      logic [31:0] o;
      int top;
      wide = '0;
      r = x.result;
      o = f;
      top = (x.size == SZ_BYTE) ? 7 : (x.size == SZ_WORD) ? 15 : 31;
      wide = x.subtract ? ({1'b0, x.a} - {1'b0, x.b})
                        : ({1'b0, x.a} + {1'b0, x.b});
      cin = x.a ^ x.b ^ wide[31:0];
      if (x.size == SZ_BYTE) begin
         r = {24'h000000, x.result[7:0]};
      end else if (x.size == SZ_WORD) begin
         r = {16'h0000, x.result[15:0]};
      end
      // Carry out of the top bit is the carry into the next bit up.
      o[CARRY_BIT] = (top == 31) ? wide[32] :
         (x.a[top+1] ^ x.b[top+1] ^ wide[top+1]);
      o[OVF_BIT] = o[CARRY_BIT] ^ cin[top];
      o[SIGN_BIT] = r[top];
      o[ZERO_BIT] = (r == 32'h00000000);
      o[AUX_BIT] = cin[4];
      o[PARITY_BIT] = ~^x.result[7:0];
      return o;
   endfunction : alu_flags

   always_comb begin
      logic [31:0] img;
      logic [31:0] keep;
      logic [31:0] cur;
      logic [31:0] step;
      img = '0;
      keep = '0;
      cur = '0;
      step = '0;
      next_state = state;
      // General register writes.
      cur = state.gpr[gprWr.idx];
      if (gprWr.en) begin
         case (gprWr.size)
            SZ_DWORD: cur = gprWr.data;
            SZ_WORD: cur[15:0] = gprWr.data[15:0];
            SZ_BYTE: begin
               if (gprWr.highByte && !gprWr.idx[2]) begin
                  cur[15:8] = gprWr.data[7:0];
               end else if (!gprWr.idx[2]) begin
                  cur[7:0] = gprWr.data[7:0];
               end
            end
            default: cur = state.gpr[gprWr.idx];
         endcase
         next_state.gpr[gprWr.idx] = cur;
      end
      // String index stepping after the access.
      if (stringStep) begin
         step = (stringSize == SZ_BYTE) ? 32'h00000001 :
                (stringSize == SZ_WORD) ? 32'h00000002 : 32'h00000004;
         for (int i = 6; i <= 7; i++) begin
            next_state.gpr[i - 1] = state.flags[DIR_BIT] ?
               state.gpr[i - 1] - step : state.gpr[i - 1] + step;
         end
      end
      // Instruction pointer.
      if (ipLoad) begin
         next_state.ip = ipNext;
      end
      // Flag updates.
      img = state.flags;
      case (flagSrc)
         FS_ALU: img = alu_flags(alu, state.flags);
         FS_TASK: img = flagImage;
         FS_POP, FS_INTERRUPT_RETURN: begin
            keep = 32'h00000000;
            if (flagSrc == FS_POP || current_privilege != PRIV0) begin
               keep[VLEG_BIT] = 1'b1;
            end
            if (current_privilege != PRIV0) begin
               keep[IO_PRIVILEGE_FIELD_HI:IO_PRIVILEGE_FIELD_LO] = 2'b11;
            end
            if (protection_enable &&
                current_privilege > state.flags[IO_PRIVILEGE_FIELD_HI:IO_PRIVILEGE_FIELD_LO]) begin
               keep[INTEN_BIT] = 1'b1;
            end
            img = (flagImage & ~keep) | (state.flags & keep);
         end
         default: img = state.flags;
      endcase
      if (taskNested) begin
         img[NEST_BIT] = 1'b1;
      end
      // A clean instruction clears resume unless it loaded an image.
      if (instrDone && !instrFault && flagSrc != FS_POP &&
          flagSrc != FS_INTERRUPT_RETURN && flagSrc != FS_TASK) begin
         img[RESUME_BIT] = 1'b0;
      end
      // Real mode cannot hold the legacy flag.
      if (!protection_enable) begin
         img[VLEG_BIT] = 1'b0;
      end
      next_state.flags = (img & FLAG_DEFINED_MASK) | FLAG_FIXED_VALUE;
      // Registered reads.
      cur = state.gpr[gprRdIdx];
      case (gprRdSize)
         SZ_DWORD: next_state.rdData = cur;
         SZ_WORD: next_state.rdData = {16'h0000, cur[15:0]};
         SZ_BYTE: next_state.rdData = (gprRdHigh && !gprRdIdx[2]) ?
            {24'h000000, cur[15:8]} : {24'h000000, cur[7:0]};
         default: next_state.rdData = cur;
      endcase
      // Exceptions: privileged or denied IO faults first, then debug.
      next_state.exc = 1'b0;
      next_state.vec = 8'h00;
      if ((legacyMode && privOpcode) || (ioInstr && !ioOk && legacyMode)) begin
         next_state.exc = 1'b1;
         next_state.vec = EXC_GP;
      end else if (instrDone && !instrFault &&
                   (state.flags[TRAP_BIT] ||
                    (debugHit && !state.flags[RESUME_BIT]))) begin
         next_state.exc = 1'b1;
         next_state.vec = EXC_DEBUG;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= '0;
         state.flags <= FLAG_RESET;
         state.ip <= IP_RESET;
      end else begin
         state <= next_state;
      end
   end

   carf_seg_unit u_seg (
      .sys_clk(sys_clk),
      .rst(rst),
      .legacyLoads(!protection_enable || legacyMode),
      .segWr(segWr),
      .memRef(memRef),
      .memChk(memChk),
      .selOut(selOut)
   );

   assign gprRdData = state.rdData;
   // Address formation uses whole registers, never the byte views.
   assign addrRegData = state.gpr[gprRdIdx];
   assign instruction_pointer = state.ip;
   assign ipShort = state.ip[15:0];
   assign processor_flags = state.flags;
   // Pushed images never show the legacy flag.
   assign flag_push = state.flags & ~(32'h00000001 << VLEG_BIT);
   assign ioNeedsBitmap = protection_enable && !legacyMode && !ioOk;
   assign excRaise = state.exc;
   assign excVector = state.vec;
   assign irqTaken = maskable_irq_input && state.flags[INTEN_BIT];
   assign iretInterTask = protection_enable && state.flags[NEST_BIT];
endmodule : carf_regfile

// >>> carf_seg_unit.sv
// Purpose: Segment selectors with hidden descriptor caches and checks.
// Assumes: Protected-mode descriptors arrive already fetched from memory.
// Notes: Offset above limit or forbidden access type raises a fault flag.
`timescale 1ns/10ps
module carf_seg_unit
   import carf_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Mode.
   input wire logic legacyLoads,
   // Load and reference.
   input wire carf_seg_wr_t segWr,
   input wire carf_memref_t memRef,
   // Results.
   output carf_memchk_t memChk,
   output logic [15:0] selOut [NUM_SEG]
);
   typedef struct packed {
      logic [NUM_SEG-1:0][15:0] sel;
      carf_desc_t [NUM_SEG-1:0] cache;
      carf_memchk_t chk;
   } carf_seg_state_t;

   carf_seg_state_t state;
   carf_seg_state_t next_state;

   always_comb begin
      carf_desc_t d;
      d = '0;
      next_state = state;
      if (segWr.en && segWr.seg < 3'(NUM_SEG)) begin
         next_state.sel[segWr.seg] = segWr.selector;
         d = state.cache[segWr.seg];
         if (legacyLoads) begin
            // The base follows the selector; limit and attributes reload their real-mode values.
            d.base = 32'(segWr.selector) << SEL_SHIFT;
            d.limit = REAL_LIMIT;
            d.attr = REAL_ATTR;
         end else begin
            d = segWr.desc;
         end
         next_state.cache[segWr.seg] = d;
      end
      next_state.chk = '0;
      if (memRef.valid && memRef.seg < 3'(NUM_SEG)) begin
         d = state.cache[memRef.seg];
         next_state.chk.linear = d.base + memRef.offset;
         next_state.chk.limitFault = memRef.offset > d.limit;
         // Attribute low nibble lists permitted access types.
         next_state.chk.attrFault =
            (memRef.accessType & ~d.attr[3:0]) != 4'h0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= '0;
         for (int i = 0; i < NUM_SEG; i++) begin
            state.cache[i].limit <= REAL_LIMIT;
            state.cache[i].attr <= REAL_ATTR;
         end
      end else begin
         state <= next_state;
      end
   end

   assign memChk = state.chk;
   generate
      for (genvar g = 0; g < NUM_SEG; g++) begin : g_sel
         assign selOut[g] = state.sel[g];
      end
   endgenerate
endmodule : carf_seg_unit

// >>> tb_carf_regfile.sv
// Purpose: Directed self-checking bench for the register file.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes: Registered answers are read just after the edge that takes them.
`timescale 1ns/10ps
module tb_carf_regfile;
   import carf_pkg::*;
   logic sys_clk, rst, protection_enable, gprRdHigh, ipLoad, taskNested;
   logic instrDone, instrFault, ioInstr, privOpcode, debugHit, stringStep;
   logic maskable_irq_input, ioNeedsBitmap, excRaise, irqTaken, iretInterTask;
   logic [1:0] current_privilege;
   logic [2:0] gprRdIdx;
   logic [7:0] excVector;
   logic [15:0] ipShort;
   logic [15:0] selOut [NUM_SEG];
   logic [31:0] gprRdData, addrRegData, ipNext, instruction_pointer;
   logic [31:0] flagImage, processor_flags, flag_push;
   carf_size_t gprRdSize, stringSize;
   carf_gpr_wr_t gprWr;
   carf_flagsrc_t flagSrc;
   carf_alu_t alu;
   carf_seg_wr_t segWr;
   carf_memref_t memRef;
   carf_memchk_t memChk;
   int n_fail, n_compared;
   // Arithmetic cases: operands, result, subtract, size, status bits.
   logic [31:0] aA [4] = '{32'h7F, 32'hFF, 32'h0, 32'h7FFFFFFF};
   logic [31:0] aB [4] = '{32'h1, 32'h1, 32'h1, 32'h1};
   logic [31:0] aR [4] = '{32'h80, 32'h100, 32'hFFFFFFFF, 32'h80000000};
   logic aS [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   carf_size_t aZ [4] = '{SZ_BYTE, SZ_BYTE, SZ_WORD, SZ_DWORD};
   logic [31:0] aE [4] = '{32'h890, 32'h55, 32'h95, 32'h894};

   carf_regfile DUT (.*);

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   // One edge, then every one-shot request except taskNested, ioInstr and maskable_irq_input is withdrawn.
   task automatic pulse;
      @(posedge sys_clk);
      #1;
      gprWr.en = 1'b0;
      flagSrc = FS_NONE;
      ipLoad = 1'b0;
      instrDone = 1'b0;
      instrFault = 1'b0;
      debugHit = 1'b0;
      privOpcode = 1'b0;
      stringStep = 1'b0;
      segWr.en = 1'b0;
      memRef.valid = 1'b0;
   endtask : pulse

   initial begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      test_done();
   end

   initial begin
      rst = 1'b1;
      {protection_enable, gprRdHigh, ipLoad, taskNested, instrDone} = '0;
      {instrFault, ioInstr, privOpcode, debugHit, stringStep} = '0;
      {maskable_irq_input, current_privilege, gprRdIdx, ipNext} = '0;
      {flagImage, gprWr, alu, segWr, memRef} = '0;
      flagSrc = FS_NONE;
      gprRdSize = SZ_DWORD;
      stringSize = SZ_DWORD;
      n_fail = 0;
      n_compared = 0;
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'b0;
      check(processor_flags, FLAG_RESET);
      gprWr = '{1'b1, 3'd0, SZ_DWORD, 1'b0, 32'h12345678};
      pulse();
      gprWr = '{1'b1, 3'd0, SZ_WORD, 1'b0, 32'hFFFFABCD};
      pulse();
      check(addrRegData, 32'h1234ABCD);
      gprWr = '{1'b1, 3'd0, SZ_BYTE, 1'b1, 32'h000000EE};
      pulse();
      check(addrRegData, 32'h1234EECD);
      gprRdSize = SZ_BYTE;
      gprRdHigh = 1'b1;
      pulse();
      check(gprRdData, 32'h000000EE);
      gprRdSize = SZ_WORD;
      pulse();
      check(gprRdData, 32'h0000EECD);
      gprRdSize = SZ_DWORD;
      gprWr = '{1'b1, 3'd4, SZ_BYTE, 1'b0, 32'h00000077};
      gprRdIdx = 3'd4;
      pulse();
      check(addrRegData, 32'h0);
      ipLoad = 1'b1;
      ipNext = 32'h0001BEEF;
      pulse();
      check(instruction_pointer, 32'h0001BEEF);
      check({16'h0, ipShort}, 32'h0000BEEF);
      for (int i = 0; i < 4; i++) begin
         alu = '{aA[i], aB[i], aR[i], aS[i], aZ[i]};
         flagSrc = FS_ALU;
         pulse();
         check(processor_flags[OVF_BIT], aE[i][OVF_BIT]);
         check(processor_flags[SIGN_BIT], aE[i][SIGN_BIT]);
         check(processor_flags[ZERO_BIT], aE[i][ZERO_BIT]);
         check(processor_flags[AUX_BIT], aE[i][AUX_BIT]);
         check(processor_flags[PARITY_BIT], aE[i][PARITY_BIT]);
         check(processor_flags[CARRY_BIT], aE[i][CARRY_BIT]);
      end
      // Protected pop at privilege 3 with an all-ones image.
      protection_enable = 1'b1;
      current_privilege = 2'h3;
      flagImage = 32'hFFFFFFFF;
      flagSrc = FS_POP;
      pulse();
      check(processor_flags, 32'h00014DD7);
      check(flag_push, 32'h00014DD7);
      check({31'h0, iretInterTask}, 32'h1);
      check({31'h0, ioNeedsBitmap}, 32'h1);
      stringStep = 1'b1;
      gprRdIdx = 3'd5;
      pulse();
      check(addrRegData, 32'hFFFFFFFC);
      stringStep = 1'b1;
      stringSize = SZ_WORD;
      pulse();
      check(addrRegData, 32'hFFFFFFFA);
      instrDone = 1'b1;
      pulse();
      check(processor_flags, 32'h00004DD7);
      instrDone = 1'b1;
      pulse();
      check({23'h0, excRaise, excVector}, {23'h0, 1'b1, EXC_DEBUG});
      current_privilege = PRIV0;
      flagImage = 32'h00023200;
      flagSrc = FS_INTERRUPT_RETURN;
      maskable_irq_input = 1'b1;
      pulse();
      check(processor_flags, 32'h00023202);
      check(flag_push, 32'h00003202);
      check({31'h0, irqTaken}, 32'h1);
      stringStep = 1'b1;
      stringSize = SZ_BYTE;
      pulse();
      check(addrRegData, 32'hFFFFFFFB);
      privOpcode = 1'b1;
      pulse();
      check({23'h0, excRaise, excVector}, {23'h0, 1'b1, EXC_GP});
      flagImage = 32'h0;
      flagSrc = FS_TASK;
      taskNested = 1'b1;
      pulse();
      taskNested = 1'b0;
      check(processor_flags, 32'h00004002);
      check({31'h0, irqTaken}, 32'h0);
      check({31'h0, ioNeedsBitmap}, 32'h0);
      // A popped resume flag survives a faulted instruction only.
      flagImage = 32'h00010000;
      flagSrc = FS_POP;
      pulse();
      instrDone = 1'b1;
      instrFault = 1'b1;
      debugHit = 1'b1;
      pulse();
      check(processor_flags, 32'h00010002);
      check({31'h0, excRaise}, 32'h0);
      instrDone = 1'b1;
      debugHit = 1'b1;
      pulse();
      check(processor_flags, 32'h00000002);
      check({31'h0, excRaise}, 32'h0);
      instrDone = 1'b1;
      debugHit = 1'b1;
      pulse();
      check({23'h0, excRaise, excVector}, {23'h0, 1'b1, EXC_DEBUG});
      // Real-mode load, then a protected load through another selector.
      protection_enable = 1'b0;
      segWr = '{1'b1, 3'd3, 16'h1234, '{32'h0, 32'h0, 12'h0}};
      pulse();
      check({16'h0, selOut[3]}, 32'h00001234);
      memRef = '{1'b1, 3'd3, 32'h10, 4'h1};
      pulse();
      check(memChk.linear, 32'h00012350);
      check({30'h0, memChk.attrFault, memChk.limitFault}, 32'h0);
      memRef = '{1'b1, 3'd3, 32'h10000, 4'h4};
      pulse();
      check({31'h0, memChk.limitFault}, 32'h1);
      check({31'h0, memChk.attrFault}, 32'h1);
      protection_enable = 1'b1;
      segWr = '{1'b1, 3'd2, 16'h0008, '{32'h00100000, 32'hFF, 12'h00F}};
      pulse();
      memRef = '{1'b1, 3'd2, 32'h20, 4'h1};
      pulse();
      check(memChk.linear, 32'h00100020);
      check({31'h0, memChk.limitFault}, 32'h0);
      memRef = '{1'b1, 3'd2, 32'h100, 4'h1};
      pulse();
      check({31'h0, memChk.limitFault}, 32'h1);
      test_done();
   end
endmodule : tb_carf_regfile

bind carf_regfile carf_checker chk (.*);
